/* logic/rtcc_pkg.sv */
package rtcc_pkg;

   // ------------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------------
   localparam int          ADDR_W       = 8;
   localparam int          DATA_W       = 32;
   localparam int          REG_W        = 16;
   localparam logic [3:0]  STRB_WORD    = 4'hf;
   localparam logic [1:0]  WORD_ALIGN   = 2'h0;

   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CTRL_LOW   = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_PLOAD_HI   = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_PLOAD_LO   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_DIVIDER_HI = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_DIVIDER_LO = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_TIME_HI    = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_TIME_LO    = 8'h1c;
   localparam logic [ADDR_W-1:0] OFF_ALARM_HI   = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_ALARM_LO   = 8'h24;

   // ------------------------------------------------------------------
   // Field positions (bits 0 to 3 shared by enable and request registers)
   // ------------------------------------------------------------------
   localparam int BIT_SECONDS   = 0;
   localparam int BIT_ALARM     = 1;
   localparam int BIT_OVERFLOW  = 2;
   localparam int BIT_GLOBAL    = 3;
   localparam int BIT_CFG_MODE  = 4;
   localparam int BIT_WR_DONE   = 5;
   localparam int NUM_IRQ       = 4;
   localparam int PLOAD_HI_W    = 4;

   // ------------------------------------------------------------------
   // Divider shape, reset values and transfer timing
   // ------------------------------------------------------------------
   localparam int                FIXED_DIV_W  = 6;
   localparam int                PRESC_W      = 20;
   localparam int                TIME_W       = 32;
   localparam logic [NUM_IRQ-1:0] IRQ_EN_RST  = 4'h0;
   localparam logic [PRESC_W-1:0] PLOAD_RST   = 20'h001ff;
   localparam logic [PRESC_W-1:0] DIVIDER_RST = 20'h08000;
   localparam logic [TIME_W-1:0]  TIME_RST    = 32'h00000000;
   localparam logic [TIME_W-1:0]  ALARM_RST   = 32'hffffffff;
   localparam logic [TIME_W-1:0]  TIME_MAX    = 32'hffffffff;
   localparam logic [1:0]         XFER_EDGES  = 2'h3;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
      logic [3:0]        pstrb;
   } rtcc_apb_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] prdata;
      logic              pready;
      logic              pslverr;
   } rtcc_apb_rsp_t;

   typedef struct packed {
      logic global_irq;
      logic overflow_irq;
      logic alarm_irq;
      logic seconds_irq;
   } rtcc_irq_t;

endpackage : rtcc_pkg

/* logic/rtcc_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser; only the second stage leaves the module.
module rtcc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } rtcc_sync_t;

   rtcc_sync_t cur_ff;
   rtcc_sync_t nxt_cur;

   // The first stage feeds nothing but the second stage.
   always_comb begin
      nxt_cur        = cur_ff;
      nxt_cur.stage1 = d;
      nxt_cur.stage2 = cur_ff.stage1;
   end

   // Synchronous reset to a quiet level.
   always_ff @(posedge clk) begin
      if (rst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign q = cur_ff.stage2;
endmodule : rtcc_sync

/* logic/rtcc_presc.sv */
`timescale 1ns/1ps
// Fixed 1/64 stage followed by a reloading down divider.
module rtcc_presc
   import rtcc_pkg::*;
#(
   parameter int FIX_W = FIXED_DIV_W,
   parameter int DIV_W = PRESC_W
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ext_edge,
   input  wire logic             run,
   input  wire logic             reload,
   input  wire logic [DIV_W-1:0] load_val,
   output logic                  tick,
   output logic      [DIV_W-1:0] div_val
);
   typedef struct packed {
      logic [FIX_W-1:0] fix;
      logic [DIV_W-1:0] div;
      logic             tick;
   } rtcc_presc_t;

   rtcc_presc_t cur_ff;
   rtcc_presc_t nxt_cur;

   // Tick period is 64 * (load_val + 1) external edges.
   always_comb begin
      nxt_cur      = cur_ff;
      nxt_cur.tick = 1'b0;
      if (reload) begin
         nxt_cur.fix = '0;
         nxt_cur.div = load_val;
      end else if (run && ext_edge) begin
         nxt_cur.fix = cur_ff.fix + FIX_W'(1);
         if (&cur_ff.fix) begin
            if (cur_ff.div == '0) begin
               nxt_cur.div  = load_val;
               nxt_cur.tick = 1'b1;
            end else begin
               nxt_cur.div = cur_ff.div - DIV_W'(1);
            end
         end
      end
   end

   // A system reset clears the fixed stage and loads DIVIDER_RST into the down divider.
   always_ff @(posedge clk) begin
      if (rst) begin
         cur_ff.fix  <= '0;
         cur_ff.div  <= DIV_W'(DIVIDER_RST);
         cur_ff.tick <= 1'b0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign tick    = cur_ff.tick;
   assign div_val = cur_ff.div;
endmodule : rtcc_presc

/* logic/rtcc_core.sv */
`timescale 1ns/1ps
module rtcc_core
   import rtcc_pkg::*;
#(
   parameter logic [PRESC_W-1:0] PLOAD_INIT = PLOAD_RST,
   parameter logic [TIME_W-1:0]  ALARM_INIT = ALARM_RST
) (
   input  wire logic          CLOCK,
   input  wire logic          RST,
   input  wire logic          EXT_CLK,
   input  wire logic          PERIPH_CLOCK_GATE,
   input  wire logic          MAIN_PWR_OK,
   input  wire rtcc_apb_req_t APB_REQ,
   output rtcc_apb_rsp_t      APB_RSP,
   output rtcc_irq_t          IRQ_OUT
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic                ext_dly;
      logic [NUM_IRQ-1:0]  irq_en;
      logic [NUM_IRQ-1:0]  req_flags;
      logic                cfg_mode;
      logic                wr_done;
      logic [1:0]          xfer_edges;
      logic                pend_pload;
      logic                pend_time;
      logic                pend_alarm;
      logic [PRESC_W-1:0]  pload_stage;
      logic [TIME_W-1:0]   time_stage;
      logic [TIME_W-1:0]   alarm_stage;
      logic [PRESC_W-1:0]  pload;
      logic [TIME_W-1:0]   time_count;
      logic [TIME_W-1:0]   alarm_val;
      logic                reload;
      logic [DATA_W-1:0]   prdata;
      logic                pslverr;
      rtcc_irq_t           irq;
   } rtcc_core_t;

   rtcc_core_t         cur_ff;
   rtcc_core_t         nxt_cur;
   logic               ext_sync;
   logic               ext_edge;
   logic               tick;
   logic [PRESC_W-1:0] div_val;
   logic               setup_phase;
   logic               access_phase;
   logic               bus_live;
   logic               addr_known;
   logic               addr_guarded;
   logic               addr_readonly;
   logic               wr_ok;
   logic [REG_W-1:0]   wdata16;
   logic [REG_W-1:0]   rdata16;

   // ------------------------------------------------------------------
   // Slow clock sampling and divider chain
   // ------------------------------------------------------------------

   // The slow clock is only sampled, so it must stay well below CLOCK.
   rtcc_sync #(
      .W (1)
   ) u_ext_sync (
      .clk (CLOCK),
      .rst (RST),
      .d   (EXT_CLK),
      .q   (ext_sync)
   );

   // Rising edge seen on the synchronised level only.
   assign ext_edge = ext_sync & ~cur_ff.ext_dly;

   rtcc_presc #(
      .FIX_W (FIXED_DIV_W),
      .DIV_W (PRESC_W)
   ) u_presc (
      .clk      (CLOCK),
      .rst      (RST),
      .ext_edge (ext_edge),
      .run      (PERIPH_CLOCK_GATE),
      .reload   (cur_ff.reload),
      .load_val (cur_ff.pload),
      .tick     (tick),
      .div_val  (div_val)
   );

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------

   // With main power gone the slave ignores the bus completely.
   assign bus_live     = MAIN_PWR_OK;
   assign setup_phase  = bus_live & APB_REQ.psel & ~APB_REQ.penable;
   assign access_phase = bus_live & APB_REQ.psel & APB_REQ.penable;
   assign wdata16      = APB_REQ.pwdata[REG_W-1:0];

   // Address classification, word aligned only.
   always_comb begin
      addr_known    = 1'b1;
      addr_guarded  = 1'b0;
      addr_readonly = 1'b0;
      if (APB_REQ.paddr[1:0] != WORD_ALIGN) begin
         addr_known = 1'b0;
      end else if (APB_REQ.paddr == OFF_IRQ_ENABLE || APB_REQ.paddr == OFF_CTRL_LOW) begin
         addr_known = 1'b1;
      end else if (APB_REQ.paddr == OFF_PLOAD_HI || APB_REQ.paddr == OFF_PLOAD_LO) begin
         addr_guarded = 1'b1;
      end else if (APB_REQ.paddr == OFF_TIME_HI || APB_REQ.paddr == OFF_TIME_LO) begin
         addr_guarded = 1'b1;
      end else if (APB_REQ.paddr == OFF_ALARM_HI || APB_REQ.paddr == OFF_ALARM_LO) begin
         addr_guarded = 1'b1;
      end else if (APB_REQ.paddr == OFF_DIVIDER_HI || APB_REQ.paddr == OFF_DIVIDER_LO) begin
         addr_readonly = 1'b1;
      end else begin
         addr_known = 1'b0;
      end
   end

   // A write lands only if full width, free, mapped, writable and permitted.
   assign wr_ok = APB_REQ.pwrite
                & (APB_REQ.pstrb == STRB_WORD)
                & cur_ff.wr_done
                & addr_known
                & ~addr_readonly
                & (~addr_guarded | cur_ff.cfg_mode);

   // Read multiplexer; reserved bits come back as zero.
   always_comb begin
      rdata16 = '0;
      if (APB_REQ.paddr[1:0] != WORD_ALIGN) begin
         rdata16 = '0;
      end else if (APB_REQ.paddr == OFF_IRQ_ENABLE) begin
         rdata16[NUM_IRQ-1:0] = cur_ff.irq_en;
      end else if (APB_REQ.paddr == OFF_CTRL_LOW) begin
         rdata16[NUM_IRQ-1:0]  = cur_ff.req_flags;
         rdata16[BIT_CFG_MODE] = cur_ff.cfg_mode;
         rdata16[BIT_WR_DONE]  = cur_ff.wr_done;
      end else if (APB_REQ.paddr == OFF_PLOAD_HI) begin
         rdata16[PLOAD_HI_W-1:0] = cur_ff.pload[PRESC_W-1:REG_W];
      end else if (APB_REQ.paddr == OFF_PLOAD_LO) begin
         rdata16 = cur_ff.pload[REG_W-1:0];
      end else if (APB_REQ.paddr == OFF_DIVIDER_HI) begin
         rdata16[PLOAD_HI_W-1:0] = div_val[PRESC_W-1:REG_W];
      end else if (APB_REQ.paddr == OFF_DIVIDER_LO) begin
         rdata16 = div_val[REG_W-1:0];
      end else if (APB_REQ.paddr == OFF_TIME_HI) begin
         rdata16 = cur_ff.time_count[TIME_W-1:REG_W];
      end else if (APB_REQ.paddr == OFF_TIME_LO) begin
         rdata16 = cur_ff.time_count[REG_W-1:0];
      end else if (APB_REQ.paddr == OFF_ALARM_HI) begin
         rdata16 = cur_ff.alarm_val[TIME_W-1:REG_W];
      end else if (APB_REQ.paddr == OFF_ALARM_LO) begin
         rdata16 = cur_ff.alarm_val[REG_W-1:0];
      end else begin
         rdata16 = '0;
      end
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic [NUM_IRQ-1:0] events;
      logic [TIME_W-1:0]  time_inc;
      events   = '0;
      time_inc = '0;
      nxt_cur         = cur_ff;
      nxt_cur.ext_dly = ext_sync;
      nxt_cur.reload  = 1'b0;

      // Setup phase captures read data and the error answer, so the access
      // phase can complete with no wait state.
      if (setup_phase) begin
         nxt_cur.prdata  = {{(DATA_W-REG_W){1'b0}}, rdata16};
         nxt_cur.pslverr = APB_REQ.pwrite ? ~wr_ok : ~addr_known;
      end else if (!bus_live) begin
         nxt_cur.prdata  = '0;
         nxt_cur.pslverr = 1'b0;
      end

      // Register writes take effect in the access phase.
      if (access_phase && wr_ok) begin
         if (APB_REQ.paddr == OFF_IRQ_ENABLE) begin
            nxt_cur.irq_en = wdata16[NUM_IRQ-1:0];
         end else if (APB_REQ.paddr == OFF_CTRL_LOW) begin
            // Writing zero clears a flag, writing one leaves it alone.
            nxt_cur.req_flags = cur_ff.req_flags & wdata16[NUM_IRQ-1:0];
            nxt_cur.cfg_mode  = wdata16[BIT_CFG_MODE];
            if (cur_ff.cfg_mode && !wdata16[BIT_CFG_MODE]) begin
               nxt_cur.wr_done    = 1'b0;
               nxt_cur.xfer_edges = '0;
            end
         end else if (APB_REQ.paddr == OFF_PLOAD_HI) begin
            nxt_cur.pload_stage[PRESC_W-1:REG_W] = wdata16[PLOAD_HI_W-1:0];
            nxt_cur.pend_pload = 1'b1;
         end else if (APB_REQ.paddr == OFF_PLOAD_LO) begin
            nxt_cur.pload_stage[REG_W-1:0] = wdata16;
            nxt_cur.pend_pload = 1'b1;
         end else if (APB_REQ.paddr == OFF_TIME_HI) begin
            nxt_cur.time_stage[TIME_W-1:REG_W] = wdata16;
            nxt_cur.pend_time = 1'b1;
         end else if (APB_REQ.paddr == OFF_TIME_LO) begin
            nxt_cur.time_stage[REG_W-1:0] = wdata16;
            nxt_cur.pend_time = 1'b1;
         end else if (APB_REQ.paddr == OFF_ALARM_HI) begin
            nxt_cur.alarm_stage[TIME_W-1:REG_W] = wdata16;
            nxt_cur.pend_alarm = 1'b1;
         end else if (APB_REQ.paddr == OFF_ALARM_LO) begin
            nxt_cur.alarm_stage[REG_W-1:0] = wdata16;
            nxt_cur.pend_alarm = 1'b1;
         end
      end

      // Time counter advances once per tick.
      time_inc = cur_ff.time_count + TIME_W'(1);
      if (tick) begin
         nxt_cur.time_count    = time_inc;
         events[BIT_SECONDS]   = 1'b1;
         events[BIT_OVERFLOW]  = (cur_ff.time_count == TIME_MAX);
         events[BIT_ALARM]     = (time_inc == cur_ff.alarm_val);
      end
      events[BIT_GLOBAL] = events[BIT_SECONDS] | events[BIT_ALARM]
                         | events[BIT_OVERFLOW];

      // The staged values move into the core only after three slow edges,
      // which mimics the hand-off to a core on the slow clock.
      if (!cur_ff.wr_done && ext_edge) begin
         if (cur_ff.xfer_edges == XFER_EDGES - 2'h1) begin
            nxt_cur.wr_done    = 1'b1;
            nxt_cur.xfer_edges = '0;
            if (cur_ff.pend_pload) begin
               nxt_cur.pload = cur_ff.pload_stage;
            end
            if (cur_ff.pend_time) begin
               nxt_cur.time_count = cur_ff.time_stage;
            end
            if (cur_ff.pend_alarm) begin
               nxt_cur.alarm_val = cur_ff.alarm_stage;
            end
            // The divider restarts after a new load or counter value.
            nxt_cur.reload     = cur_ff.pend_pload | cur_ff.pend_time;
            nxt_cur.pend_pload = 1'b0;
            nxt_cur.pend_time  = 1'b0;
            nxt_cur.pend_alarm = 1'b0;
         end else begin
            nxt_cur.xfer_edges = cur_ff.xfer_edges + 2'h1;
         end
      end

      // An event in the same cycle as a software clear still sets its flag.
      nxt_cur.req_flags = nxt_cur.req_flags | events;

      // Flags always record; outputs follow only the enabled ones.
      nxt_cur.irq.seconds_irq  = cur_ff.req_flags[BIT_SECONDS]
                               & cur_ff.irq_en[BIT_SECONDS];
      nxt_cur.irq.alarm_irq    = cur_ff.req_flags[BIT_ALARM]
                               & cur_ff.irq_en[BIT_ALARM];
      nxt_cur.irq.overflow_irq = cur_ff.req_flags[BIT_OVERFLOW]
                               & cur_ff.irq_en[BIT_OVERFLOW];
      nxt_cur.irq.global_irq   = cur_ff.req_flags[BIT_GLOBAL]
                               & cur_ff.irq_en[BIT_GLOBAL];
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------

   // System reset clears the time counter, loads alarm and load values from their parameters and masks every source.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         cur_ff             <= '0;
         cur_ff.irq_en      <= IRQ_EN_RST;
         cur_ff.wr_done     <= 1'b1;
         cur_ff.pload_stage <= PLOAD_INIT;
         cur_ff.pload       <= PLOAD_INIT;
         cur_ff.time_stage  <= TIME_RST;
         cur_ff.time_count  <= TIME_RST;
         cur_ff.alarm_stage <= ALARM_INIT;
         cur_ff.alarm_val   <= ALARM_INIT;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------

   // Zero wait states; ready is held high even when isolated so a stray
   // access can never hang the bus.
   assign APB_RSP.pready  = 1'b1;
   assign APB_RSP.prdata  = cur_ff.prdata;
   assign APB_RSP.pslverr = cur_ff.pslverr & access_phase;
   assign IRQ_OUT         = cur_ff.irq;

endmodule : rtcc_core

/* test/rtcc_chk.sv */
`timescale 1ns/1ps
// Watches the bus and interrupt pins of the counter core.
module rtcc_chk
   import rtcc_pkg::*;
(
   input wire logic          CLOCK,
   input wire logic          RST,
   input wire logic          EXT_CLK,
   input wire logic          PERIPH_CLOCK_GATE,
   input wire logic          MAIN_PWR_OK,
   input wire rtcc_apb_req_t APB_REQ,
   input wire rtcc_apb_rsp_t APB_RSP,
   input wire rtcc_irq_t     IRQ_OUT
);
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   // ----------------------------------------------------------------
   // Bus phases, counted only while the slave is powered.
   // ----------------------------------------------------------------
   logic setup_ph;
   logic acc_ph;
   assign setup_ph = APB_REQ.psel & ~APB_REQ.penable & MAIN_PWR_OK;
   assign acc_ph   = APB_REQ.psel & APB_REQ.penable & MAIN_PWR_OK;
   a_rst_quiet: assert property ($fell(RST) |-> IRQ_OUT == '0 && APB_RSP == 34'h2)
      else $error("outputs not quiet after reset");
   a_upper_zero: assert property (APB_RSP.prdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_byte_refused: assert property (setup_ph && APB_REQ.pwrite && APB_REQ.pstrb != STRB_WORD
      ##1 acc_ph |-> APB_RSP.pslverr)
      else $error("partial write accepted");
   a_bad_addr: assert property (setup_ph && (APB_REQ.paddr > OFF_ALARM_LO
      || APB_REQ.paddr[1:0] != WORD_ALIGN) ##1 acc_ph |-> APB_RSP.pslverr)
      else $error("bad address accepted");
   a_en_reserved: assert property (setup_ph && !APB_REQ.pwrite
      && APB_REQ.paddr == OFF_IRQ_ENABLE ##1 acc_ph |-> APB_RSP.prdata[15:4] == '0)
      else $error("enable reserved bits not zero");
   a_ctl_reserved: assert property (setup_ph && !APB_REQ.pwrite
      && APB_REQ.paddr == OFF_CTRL_LOW ##1 acc_ph |-> APB_RSP.prdata[15:6] == '0)
      else $error("control reserved bits not zero");
   a_mask_quiet: assert property (acc_ph && APB_REQ.pwrite && APB_REQ.paddr == OFF_IRQ_ENABLE
      && APB_REQ.pwdata[3:0] == 4'h0 && !APB_RSP.pslverr |-> ##2 IRQ_OUT == '0)
      else $error("interrupt while masked");
   a_pwr_quiet: assert property (!MAIN_PWR_OK [*2] |-> APB_RSP.prdata == '0
      && !APB_RSP.pslverr)
      else $error("bus answers without power");
   a_data_hold: assert property (acc_ph |=> $stable(APB_RSP.prdata))
      else $error("read data moved after access");
endmodule : rtcc_chk

/* test/rtcc_apbm.sv */
`timescale 1ns/1ps
// Processor side of the register bus; one transfer at a time.
module rtcc_apbm
   import rtcc_pkg::*;
(
   input  wire rtcc_apb_rsp_t rsp,
   input  wire logic          clk,
   output rtcc_apb_req_t      req
);
   initial begin
      req = '0;
   end
   // Setup, then access held until ready is seen high at an edge.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
                       input logic [3:0] s, output logic [15:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      req = '{1'b1, 1'b0, wr, a, {16'h0000, d}, s};
      @(posedge clk);
      #1;
      req.penable = 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 16);
      rd = rsp.prdata[15:0];
      #1;
      // A released bus shows inverted leftovers so stale values never look valid.
      req = '{1'b0, 1'b0, ~wr, ~a, ~req.pwdata, ~s};
   endtask : xfer
endmodule : rtcc_apbm

/* test/rtcc_core_bench.sv */
`timescale 1ns/1ps
module rtcc_core_bench
   import rtcc_pkg::*;
;
   logic          clk = 1'b0;
   logic          rst = 1'b1;
   logic          ext_clk = 1'b0;
   logic          gate = 1'b0;
   logic          pwr_ok = 1'b1;
   rtcc_apb_req_t req;
   rtcc_apb_rsp_t rsp;
   rtcc_irq_t     irq;
   logic [32:0]   exp_q[$];
   logic [15:0]   rd;
   logic [31:0]   seed = 32'h266bebd4;
   int            error_cnt = 0;
   int            cmp_count = 0;
   int            n;
   realtime       t0;
   logic [23:0]   rst_tab[10] = '{24'h000000, 24'h040020, 24'h080000, 24'h0c0001,
                                  24'h100000, 24'h148000, 24'h180000, 24'h1c0000,
                                  24'h20ffff, 24'h24ffff};
   // A tiny load value keeps one tick near a thousand system cycles.
   rtcc_core #(.PLOAD_INIT(20'h00001), .ALARM_INIT(ALARM_RST)) rtcc_core_i (
      .CLOCK(clk), .RST(rst), .EXT_CLK(ext_clk), .PERIPH_CLOCK_GATE(gate),
      .MAIN_PWR_OK(pwr_ok), .APB_REQ(req), .APB_RSP(rsp), .IRQ_OUT(irq));
   rtcc_apbm rtcc_apbm_i (.rsp(rsp), .clk(clk), .req(req));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // Slow clock about eight times slower, unrelated in phase.
   initial begin
      forever #20.3 ext_clk = ~ext_clk;
   end
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction : rnd
   task automatic fail(input string m);
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
   endtask : fail
   task automatic chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) fail(m);
   endtask : chk
   task automatic cmp_irq(input rtcc_irq_t e);
      chk(irq === e, "interrupt pins differ");
   endtask : cmp_irq
   // Note the answer expected, then run one transfer.
   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] s, input logic e, input logic [31:0] mx);
      exp_q.push_back({e, mx});
      rtcc_apbm_i.xfer(w, a, d, s, rd);
   endtask : acc
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic e);
      acc(1'b1, a, d, STRB_WORD, e, 32'h0);
   endtask : wr
   task automatic rdx(input logic [7:0] a, input logic [15:0] x);
      acc(1'b0, a, 16'h0000, STRB_WORD, 1'b0, {16'hffff, x});
   endtask : rdx
   task automatic wait_irq(input int b);
      for (n = 0; irq[b] !== 1'b1 && n < 4000; n++) begin
         @(posedge clk);
         #1;
      end
      chk(n < 4000, "no interrupt");
   endtask : wait_irq
   // Every completed access is checked against the oldest note.
   always @(posedge clk) begin
      if (req.psel === 1'b1 && req.penable === 1'b1 && rsp.pready === 1'b1) begin
         chk(exp_q.size() > 0 && rsp.pslverr === exp_q[0][32]
             && (rsp.prdata[15:0] & exp_q[0][31:16]) === exp_q[0][15:0], "bus answer differs");
         if (exp_q.size() > 0) void'(exp_q.pop_front());
      end
   end
   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      #100us;
      fail("watchdog");
      end_sim();
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      repeat (1200) @(posedge clk); // Gate low: nothing may count.
      foreach (rst_tab[i]) rdx(rst_tab[i][23:16], rst_tab[i][15:0]);
      gate = 1'b1;
      acc(1'b1, OFF_IRQ_ENABLE, 16'h000f, 4'h1, 1'b1, 32'h0);
      rdx(OFF_IRQ_ENABLE, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_IRQ_ENABLE, (16'h1 << i) | (rnd() & 16'hfff0), 1'b0);
         rdx(OFF_IRQ_ENABLE, 16'h1 << i);
      end
      wr(OFF_IRQ_ENABLE, 16'h0000, 1'b0);
      wr(OFF_TIME_LO, 16'h1234, 1'b1);
      acc(1'b0, 8'h28, 16'h0, STRB_WORD, 1'b1, 32'hffff0000);
      acc(1'b0, 8'h02, 16'h0, STRB_WORD, 1'b1, 32'hffff0000);
      wr(OFF_CTRL_LOW, 16'h0010, 1'b0);
      wr(OFF_DIVIDER_LO, rnd(), 1'b1);
      wr(OFF_ALARM_HI, 16'hffff, 1'b0);
      wr(OFF_TIME_HI, 16'hffff, 1'b0);
      wr(OFF_TIME_LO, 16'hfffe, 1'b0);
      rdx(OFF_TIME_LO, 16'h0000);
      wr(OFF_CTRL_LOW, 16'h0000, 1'b0);
      t0 = $realtime;
      acc(1'b0, OFF_CTRL_LOW, 16'h0, STRB_WORD, 1'b0, 32'h00200000);
      wr(OFF_IRQ_ENABLE, 16'h0001, 1'b1);
      n = 0;
      do begin
         acc(1'b0, OFF_CTRL_LOW, 16'h0, STRB_WORD, 1'b0, 32'h0);
         n++;
      end while (rd[5] !== 1'b1 && n < 100);
      // Three slow edges span at least two full slow periods.
      chk($realtime - t0 >= 81.2 && n < 100, "update finished too early or never");
      rdx(OFF_TIME_HI, 16'hffff);
      rdx(OFF_TIME_LO, 16'hfffe);
      rdx(OFF_ALARM_HI, 16'hffff);
      wr(OFF_CTRL_LOW, 16'h0000, 1'b0);
      wr(OFF_IRQ_ENABLE, 16'h000f, 1'b0);
      wait_irq(BIT_SECONDS);
      cmp_irq(4'hb);
      wr(OFF_CTRL_LOW, 16'h000f, 1'b0);
      rdx(OFF_CTRL_LOW, 16'h002b);
      wr(OFF_CTRL_LOW, 16'h000e, 1'b0);
      rdx(OFF_CTRL_LOW, 16'h002a);
      cmp_irq(4'ha);
      wr(OFF_CTRL_LOW, 16'h0000, 1'b0);
      wait_irq(BIT_OVERFLOW);
      cmp_irq(4'hd);
      rdx(OFF_TIME_LO, 16'h0000);
      wr(OFF_IRQ_ENABLE, 16'h0000, 1'b0);
      repeat (2) @(posedge clk);
      #1 cmp_irq(4'h0);
      pwr_ok = 1'b0;
      wr(OFF_IRQ_ENABLE, 16'h000f, 1'b0);
      acc(1'b0, OFF_CTRL_LOW, 16'h0, STRB_WORD, 1'b0, 32'hffff0000);
      pwr_ok = 1'b1;
      rdx(OFF_IRQ_ENABLE, 16'h0000);
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      rdx(OFF_TIME_HI, 16'h0000);
      rdx(OFF_CTRL_LOW, 16'h0020);
      end_sim();
   end
endmodule : rtcc_core_bench
bind rtcc_core rtcc_chk rtcc_chk_i (
   .CLOCK(CLOCK), .RST(RST), .EXT_CLK(EXT_CLK), .PERIPH_CLOCK_GATE(PERIPH_CLOCK_GATE),
   .MAIN_PWR_OK(MAIN_PWR_OK), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .IRQ_OUT(IRQ_OUT));
